/* File: verilog/supervisor_ram_enable_gate.sv */
// How it works
// - Low lane select only when select and low-enable low
// - High lane select only when select and high-enable low
// - Reset held low while supply out of range
// - Missing watchdog kick within period forces reset
// - Reset held low through power-up interval
// - Debounced pushbutton gives reset of 250 ms minimum
// - Reset pin is open drain, sensed when released
// - Host access refused while supply below trip
// - Reset kept 250 ms after supply returns
`timescale 1ns/100ps
module supervisor_ram_enable_gate
   import supervisor_pkg::*;
#(
   parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic supply_ok,
   input wire logic ram_select_in_n,
   input wire logic lower_byte_en_n,
   input wire logic upper_byte_en_n,
   input wire logic watchdog_kick_n,
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe_n,
   output logic sram_low_lane_sel_n,
   output logic sram_high_lane_sel_n,
   output logic host_access_en
);
   typedef struct packed {
      mode_t mode;
      logic [15:0] hold_ms;
      logic [15:0] wd_ms;
      logic [15:0] deb_ms;
      logic armed;
      logic [1:0] sup_s;
      logic [1:0] sel_s;
      logic [1:0] lo_en_s;
      logic [1:0] hi_en_s;
      logic [2:0] kick_s;
      logic [1:0] pin_s;
      logic pin_o;
      logic oe_n;
      logic lo_n;
      logic hi_n;
      logic acc;
   } state_t;

   // Reset pulls the pin low and closes both lanes
   localparam state_t STATE_RST = '{
      mode: MODE_FAIL, hold_ms: 16'h0000, wd_ms: 16'h0000,
      deb_ms: 16'h0000, armed: 1'b0, sup_s: 2'h0, sel_s: 2'h3,
      lo_en_s: 2'h3, hi_en_s: 2'h3, kick_s: 3'h7, pin_s: 2'h3,
      pin_o: 1'b0, oe_n: 1'b0, lo_n: 1'b1, hi_n: 1'b1, acc: 1'b0};

   function automatic logic [15:0] inc16(input logic [15:0] v);
      inc16 = v + 16'h0001;
   endfunction

   state_t s_q;
   state_t s_d;
   logic tick;
   logic kick_fall;
   logic pin_low;
   logic wd_expire;
   logic btn_fire;

   ms_tick_divider #(.DIV(MS_CYCLES)) u_div (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick(tick)
   );

   always_comb begin
      s_d = s_q;
      // Two-stage synchronisers, three for the kick; only stage 1 and above feed logic
      s_d.sup_s = {s_q.sup_s[0], supply_ok};
      s_d.sel_s = {s_q.sel_s[0], ram_select_in_n};
      s_d.lo_en_s = {s_q.lo_en_s[0], lower_byte_en_n};
      s_d.hi_en_s = {s_q.hi_en_s[0], upper_byte_en_n};
      s_d.kick_s = {s_q.kick_s[1:0], watchdog_kick_n};
      s_d.pin_s = {s_q.pin_s[0], rst_pin_in};
      kick_fall = s_q.kick_s[2] & ~s_q.kick_s[1];
      pin_low = ~s_q.pin_s[1];
      wd_expire = 1'b0;

      // Pushbutton debounce, only sensed while the pin is released
      if (s_q.mode == MODE_RUN && pin_low) begin
         if (tick && s_q.deb_ms != DEBOUNCE_MS) begin
            s_d.deb_ms = inc16(s_q.deb_ms);
         end
      end else begin
         s_d.deb_ms = 16'h0000;
      end
      // A held button must be let go before it can fire again
      btn_fire = s_q.mode == MODE_RUN && pin_low && s_q.armed &&
                 s_q.deb_ms == DEBOUNCE_MS;
      if (!pin_low) begin
         s_d.armed = 1'b1;
      end else if (btn_fire) begin
         s_d.armed = 1'b0;
      end

      case (s_q.mode)
         MODE_FAIL: begin
            if (s_q.sup_s[1]) begin
               s_d.mode = MODE_HOLD;
               s_d.hold_ms = 16'h0000;
            end
         end
         MODE_HOLD: begin
            if (tick) begin
               if (s_q.hold_ms == RST_PULSE_MS) begin
                  s_d.mode = MODE_RUN;
                  s_d.wd_ms = 16'h0000;
               end else begin
                  s_d.hold_ms = inc16(s_q.hold_ms);
               end
            end
         end
         MODE_RUN: begin
            if (kick_fall) begin
               s_d.wd_ms = 16'h0000;
            end else if (tick) begin
               if (s_q.wd_ms == WDOG_MS - 16'h0001) begin
                  wd_expire = 1'b1;
               end else begin
                  s_d.wd_ms = inc16(s_q.wd_ms);
               end
            end
            if (wd_expire || btn_fire) begin
               s_d.mode = MODE_HOLD;
               s_d.hold_ms = 16'h0000;
               s_d.wd_ms = 16'h0000;
            end
         end
         default: begin
            s_d.mode = MODE_FAIL;
         end
      endcase

      // Supply loss overrides every other state
      if (!s_q.sup_s[1]) begin
         s_d.mode = MODE_FAIL;
         s_d.hold_ms = 16'h0000;
         s_d.wd_ms = 16'h0000;
      end

      // Pin is only ever pulled low, never driven high
      s_d.pin_o = 1'b0;
      s_d.oe_n = s_d.mode == MODE_RUN;
      s_d.acc = s_d.mode == MODE_RUN;
      // Host select high leaves both lanes idle; power fail closes both
      s_d.lo_n = (s_d.mode == MODE_FAIL) | s_q.sel_s[1] |
                 s_q.lo_en_s[1];
      s_d.hi_n = (s_d.mode == MODE_FAIL) | s_q.sel_s[1] |
                 s_q.hi_en_s[1];
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rst_pin_out = s_q.pin_o;
   assign rst_pin_oe_n = s_q.oe_n;
   assign sram_low_lane_sel_n = s_q.lo_n;
   assign sram_high_lane_sel_n = s_q.hi_n;
   assign host_access_en = s_q.acc;

   low_lane_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !sram_low_lane_sel_n |-> $past(s_q.sel_s[1]) == 1'b0 &&
         $past(s_q.lo_en_s[1]) == 1'b0)
      else $error("low lane selected without both enables");

   high_lane_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !sram_high_lane_sel_n |-> $past(s_q.sel_s[1]) == 1'b0 &&
         $past(s_q.hi_en_s[1]) == 1'b0)
      else $error("high lane selected without both enables");

   fail_reset_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !s_q.sup_s[1] |=> !rst_pin_oe_n && s_q.mode == MODE_FAIL)
      else $error("reset not driven on supply loss");

   wdog_timeout_a: assert property (@(posedge mclk)
      disable iff (!rst_n)
      wd_expire && s_q.sup_s[1] |=> s_q.mode == MODE_HOLD && !rst_pin_oe_n)
      else $error("watchdog expiry did not reset");

   hold_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
      s_q.mode == MODE_HOLD |-> !rst_pin_oe_n && !host_access_en)
      else $error("reset released during hold");

   button_reset_a: assert property (@(posedge mclk)
      disable iff (!rst_n)
      btn_fire && s_q.sup_s[1] |=> s_q.mode == MODE_HOLD &&
         s_q.hold_ms == 16'h0000)
      else $error("debounced button did not start reset");

   open_drain_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !rst_pin_out && rst_pin_oe_n == (s_q.mode == MODE_RUN))
      else $error("reset pin driven high or released outside run");

   access_block_a: assert property (@(posedge mclk)
      disable iff (!rst_n)
      !s_q.sup_s[1] |=> !host_access_en)
      else $error("host access open with supply low");

   release_time_a: assert property (@(posedge mclk)
      disable iff (!rst_n)
      $rose(rst_pin_oe_n) |-> $past(s_q.hold_ms) == RST_PULSE_MS)
      else $error("reset released before full pulse");

   fail_lanes_a: assert property (@(posedge mclk) disable iff (!rst_n)
      s_q.mode == MODE_FAIL |-> sram_low_lane_sel_n && sram_high_lane_sel_n)
      else $error("lane select active in power failure");

   kick_restart_a: assert property (@(posedge mclk)
      disable iff (!rst_n)
      kick_fall && s_q.mode == MODE_RUN |=> s_q.wd_ms == 16'h0000)
      else $error("kick did not restart watchdog");
endmodule

/* File: verilog/supervisor_pkg.sv */
package supervisor_pkg;

   // Timebase: mclk at 250 MHz, divided down to a 1 ms tick
   localparam int CLK_MHZ = 250;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_US;

   // Reset pulse after power-up, pushbutton or watchdog, in ms
   localparam logic [15:0] RST_PULSE_MS = 16'h00FA;
   // Watchdog period in ms
   localparam logic [15:0] WDOG_MS = 16'h03E8;
   // Pushbutton must read low this many ms before it counts
   localparam logic [15:0] DEBOUNCE_MS = 16'h0014;

   typedef enum logic [1:0] {MODE_FAIL, MODE_HOLD, MODE_RUN} mode_t;

endpackage

/* File: verilog/ms_tick_divider.sv */
`timescale 1ns/100ps
module ms_tick_divider #(
   parameter int unsigned DIV = 250000
) (
   input wire logic mclk,
   input wire logic rst_n,
   output logic tick
);
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } div_t;

   div_t s_q;
   div_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == 32'(DIV - 1)) begin
         s_d.cnt = 32'h0000_0000;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 32'h0000_0001;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

   tick_period_a: assert property (@(posedge mclk) disable iff (!rst_n)
      tick |=> !tick) else $error("tick longer than one cycle");
endmodule

/* File: tb/host_model.sv */
`timescale 1ns/100ps
module host_model (
   input wire logic mclk,
   input wire logic kick_en,
   input wire logic button_n,
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe_n,
   output logic rst_pin_in,
   output logic watchdog_kick_n
);
   logic [8:0] cnt_q = 9'h000;
   // Pull-up holds the wire high unless the device or the button pulls it
   assign rst_pin_in = rst_pin_oe_n ? button_n : rst_pin_out;
   assign watchdog_kick_n = !(kick_en && cnt_q < 9'h004);
   always_ff @(posedge mclk) begin
      cnt_q <= cnt_q + 9'h001;
   end
endmodule

/* File: tb/supervisor_ram_enable_gate_tb_top.sv */
`timescale 1ns/100ps
module supervisor_ram_enable_gate_tb_top;
   import supervisor_pkg::*;
   localparam int MSC = 2;
   localparam int P = int'(RST_PULSE_MS);
   localparam int W = int'(WDOG_MS);
   localparam int D = int'(DEBOUNCE_MS);
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic supply_ok = 1'b0;
   logic sel_n = 1'b1;
   logic lo_n = 1'b1;
   logic hi_n = 1'b1;
   logic kick_en = 1'b0;
   logic button_n = 1'b1;
   logic kick_n, pin_in, pin_out, oe_n, low_n, high_n, acc_en;
   int num_errors = 0;
   int checks_done = 0;
   always #2 mclk = ~mclk;
   supervisor_ram_enable_gate #(.MS_CYCLES(MSC)) uut (
      .mclk(mclk), .rst_n(rst_n), .supply_ok(supply_ok),
      .ram_select_in_n(sel_n), .lower_byte_en_n(lo_n),
      .upper_byte_en_n(hi_n), .watchdog_kick_n(kick_n),
      .rst_pin_in(pin_in), .rst_pin_out(pin_out), .rst_pin_oe_n(oe_n),
      .sram_low_lane_sel_n(low_n), .sram_high_lane_sel_n(high_n),
      .host_access_en(acc_en));
   host_model cpu (
      .mclk(mclk), .kick_en(kick_en), .button_n(button_n),
      .rst_pin_out(pin_out), .rst_pin_oe_n(oe_n), .rst_pin_in(pin_in),
      .watchdog_kick_n(kick_n));
   task automatic chk(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input int n, input int lo, input int hi);
      checks_done++;
      if (n < lo || n > hi) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
      end
   endtask
   // Counts cycles until the reset pin enable reaches v, sampled settled
   task automatic wait_oe(input logic v, input int lim, output int n);
      n = 0;
      while (oe_n !== v && n < lim) begin
         @(negedge mclk);
         n++;
      end
   endtask
   task automatic power_up;
      int n;
      @(posedge mclk) supply_ok <= 1'b1;
      @(negedge mclk);
      chk(oe_n, 1'b0);
      chk(acc_en, 1'b0);
      wait_oe(1'b1, 4000, n);
      chk_rng(n, P * MSC, (P + 1) * MSC + 4);
      chk(acc_en, 1'b1);
   endtask
   task automatic watchdog;
      int n;
      wait_oe(1'b0, 3 * W * MSC, n);
      chk_rng(n, W * MSC - 2, (W + 1) * MSC + 2);
      wait_oe(1'b1, 1200, n);
      chk_rng(n, P * MSC - 1, (P + 1) * MSC + 2);
      @(posedge mclk) kick_en <= 1'b1;
      wait_oe(1'b0, 3 * W * MSC, n);
      chk(oe_n, 1'b1);
   endtask
   task automatic lanes;
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         {sel_n, hi_n, lo_n} <= i[2:0];
         repeat (4) @(posedge mclk);
         @(negedge mclk);
         chk(low_n, sel_n | lo_n);
         chk(high_n, sel_n | hi_n);
      end
   endtask
   task automatic button;
      int n;
      // A press shorter than the debounce time must not reset
      @(posedge mclk) button_n <= 1'b0;
      repeat ((D / 2) * MSC) @(posedge mclk);
      button_n <= 1'b1;
      wait_oe(1'b0, 4 * D * MSC, n);
      chk(oe_n, 1'b1);
      @(posedge mclk) button_n <= 1'b0;
      wait_oe(1'b0, 200, n);
      chk_rng(n, (D - 1) * MSC, (D + 1) * MSC + 4);
      chk(pin_out, 1'b0);
      @(posedge mclk) button_n <= 1'b1;
      wait_oe(1'b1, 1200, n);
      chk_rng(n, P * MSC - 1, (P + 1) * MSC + 2);
   endtask
   task automatic supply_fail;
      @(posedge mclk);
      {sel_n, hi_n, lo_n} <= 3'h0;
      repeat (5) @(posedge mclk);
      supply_ok <= 1'b0;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      chk(oe_n, 1'b0);
      chk(acc_en, 1'b0);
      chk(low_n, 1'b1);
      chk(high_n, 1'b1);
      power_up();
   endtask
   task automatic final_report;
      $display("errors=%0d checks=%0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      power_up();
      watchdog();
      lanes();
      button();
      supply_fail();
      final_report();
   end
   initial begin
      #(4 * 30000);
      num_errors++;
      final_report();
   end
endmodule
